// >>> logic/plc_host.sv
// Purpose: Host that programs the three-sink LED driver over its one wire.
// Assumes: The driver counts rising edges and latches after a high pause.
// Notes:   Level 0 requests shutdown; levels 1..32 are sent as edge bursts.
//
// Operation
// - Host ends each burst holding the line high past 500 us.
// - Host keeps low phases inside a burst between 0.3 us and 75 us.
// - Host keeps each high phase at least 50 ns.
// - Host keeps high phases inside a burst at most 75 us.
// - Host toggles the line no faster than 1 MHz.
`timescale 1ns/1ns
module plc_host (
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // Request port.
  input  wire logic                        req_valid,
  input  wire logic [plc_pkg::LEVEL_W-1:0] req_level,
  output logic                             req_ready,
  // Status.
  output logic                             busy,
  output logic [plc_pkg::LEVEL_W-1:0]      level_applied,
  // Single wire to the driver enable pin.
  output logic                             en_line
);
  import plc_pkg::*;

  typedef enum {ST_IDLE, ST_OFF, ST_PRELOW, ST_HIGH, ST_LOW, ST_LATCH}
    plc_state_t;

  plc_state_t               state_reg, state_next;
  logic [CNT_W-1:0]         cnt_reg, cnt_next;
  logic [LEVEL_W-1:0]       left_reg, left_next;
  logic [LEVEL_W-1:0]       tgt_reg, tgt_next;
  logic [LEVEL_W-1:0]       appl_reg, appl_next;
  logic                     line_reg, line_next;

  // Out-of-range requests are clamped, as the driver would saturate anyway.
  function automatic logic [LEVEL_W-1:0] clamp_level(
      input logic [LEVEL_W-1:0] lv);
    clamp_level = (lv > LEVEL_W'(LEVEL_MAX)) ? LEVEL_W'(LEVEL_MAX) : lv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Every new level starts from shutdown so the edge count is absolute;
  // this costs one off pause per change but needs no knowledge of state.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    left_next  = left_reg;
    tgt_next   = tgt_reg;
    appl_next  = appl_reg;
    line_next  = line_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          tgt_next   = clamp_level(req_level);
          line_next  = 1'b0;
          cnt_next   = '0;
          state_next = ST_OFF;
        end
      end
      ST_OFF: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(OFF_CYC - 1)) begin
          cnt_next = '0;
          if (tgt_reg == '0) begin
            appl_next  = '0;
            state_next = ST_IDLE;
          end else begin
            left_next  = tgt_reg;
            line_next  = 1'b1;
            state_next = ST_HIGH;
          end
        end
      end
      ST_HIGH: begin
        cnt_next = cnt_reg + 1'b1;
        if (left_reg == 6'h01) begin
          state_next = ST_LATCH;
        end else if (cnt_reg == CNT_W'(HIGH_CYC - 1)) begin
          cnt_next   = '0;
          line_next  = 1'b0;
          left_next  = left_reg - 1'b1;
          state_next = ST_LOW;
        end
      end
      ST_LOW: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(LOW_CYC - 1)) begin
          cnt_next   = '0;
          line_next  = 1'b1;
          state_next = ST_HIGH;
        end
      end
      ST_LATCH: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(LATCH_CYC - 1)) begin
          cnt_next   = '0;
          appl_next  = tgt_reg;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      left_reg  <= '0;
      tgt_reg   <= '0;
      appl_reg  <= '0;
      line_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      left_reg  <= left_next;
      tgt_reg   <= tgt_next;
      appl_reg  <= appl_next;
      line_reg  <= line_next;
    end
  end

  assign req_ready     = (state_reg == ST_IDLE);
  assign busy          = (state_reg != ST_IDLE);
  assign level_applied = appl_reg;
  assign en_line       = line_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Helper: length of the current phase of the line.
  // Seen at an edge, run_reg is the cycles the line held its previous
  // level. It sticks at its top value, so a long idle low phase cannot
  // wrap round and make a later off pause look short.
  logic [CNT_W-1:0] run_reg, run_next;
  logic             line_d_reg;
  always_comb begin
    run_next = run_reg + 1'b1;
    if (line_reg != line_d_reg) begin
      run_next = CNT_W'(1);
    end else if (run_reg == '1) begin
      run_next = run_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_reg    <= '0;
      line_d_reg <= 1'b0;
    end else begin
      line_d_reg <= line_reg;
      run_reg    <= run_next;
    end
  end

  property p_low_len;
    @(posedge ref_clk) disable iff (srst)
      ($rose(line_reg) && $past(state_reg) == ST_LOW) |->
        (run_reg >= CNT_W'(LOW_MIN_CYC) && run_reg <= CNT_W'(LOW_MAX_CYC));
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("Low phase out of range.");

  property p_high_min;
    @(posedge ref_clk) disable iff (srst)
      $fell(line_reg) && busy |-> run_reg >= CNT_W'(HIGH_MIN_CYC);
  endproperty
  a_high_min: assert property (p_high_min)
    else $error("High phase too short.");

  property p_high_max;
    @(posedge ref_clk) disable iff (srst)
      (state_reg == ST_HIGH && line_d_reg) |->
        run_reg <= CNT_W'(HIGH_MAX_CYC);
  endproperty
  a_high_max: assert property (p_high_max)
    else $error("High phase inside burst too long.");

  property p_rate;
    @(posedge ref_clk) disable iff (srst)
      $rose(line_reg) && $past(state_reg) == ST_LOW |->
        $past(line_reg, LOW_CYC)
        == 1'b0;
  endproperty
  a_rate: assert property (p_rate)
    else $error("Line toggled faster than allowed.");

  property p_latch;
    @(posedge ref_clk) disable iff (srst)
      (state_reg == ST_LATCH && state_next == ST_IDLE) |->
        line_reg && run_reg >= CNT_W'(LATCH_CYC - 1);
  endproperty
  a_latch: assert property (p_latch)
    else $error("Latch pause too short.");

  property p_apply_hold;
    @(posedge ref_clk) disable iff (srst)
      (state_reg != ST_LATCH && state_reg != ST_OFF) |=> $stable(appl_reg);
  endproperty
  a_apply_hold: assert property (p_apply_hold)
    else $error("Applied level changed outside a latch.");

  property p_off;
    @(posedge ref_clk) disable iff (srst)
      (state_reg == ST_OFF && state_next != ST_OFF) |->
        !line_reg && run_reg >= CNT_W'(OFF_CYC - 1);
  endproperty
  a_off: assert property (p_off)
    else $error("Off pause too short.");

  property p_clamp;
    @(posedge ref_clk) disable iff (srst)
      appl_reg <= LEVEL_W'(LEVEL_MAX);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("Level above 32.");
endmodule

// >>> logic/plc_pkg.sv
// Purpose: Constants for the pulse-count LED current host controller.
// Assumes: ref_clk at 50 MHz.
// Notes:   Times kept in their printed unit; cycle counts derived here.
package plc_pkg;
  localparam int CLK_MHZ          = 50;
  localparam int CLK_PERIOD_NS    = 20;
  // Latch pause and off timeout, microseconds.
  localparam int LATCH_PAUSE_US   = 500;
  localparam int OFF_TIME_US      = 500;
  // Low phase between pulses: 0.3 us min, 75 us max.
  localparam int LOW_MIN_NS       = 300;
  localparam int LOW_MAX_US       = 75;
  // High phase: 50 ns min, 75 us max.
  localparam int HIGH_MIN_NS      = 50;
  localparam int HIGH_MAX_US      = 75;
  // Fastest toggle rate, kHz (period 1000 ns).
  localparam int RATE_MAX_KHZ     = 1000;
  localparam int RATE_PERIOD_NS   = 1000000 / RATE_MAX_KHZ;
  // Least times round up; a pulse phase is half the fastest period.
  localparam int LOW_MIN_CYC  = (LOW_MIN_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int HALF_PER_CYC = (RATE_PERIOD_NS / 2 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int HIGH_MIN_CYC = (HIGH_MIN_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int LOW_CYC  = (HALF_PER_CYC > LOW_MIN_CYC) ?
                            HALF_PER_CYC : LOW_MIN_CYC;
  localparam int HIGH_CYC = (HALF_PER_CYC > HIGH_MIN_CYC) ?
                            HALF_PER_CYC : HIGH_MIN_CYC;
  // Longest times round down.
  localparam int LOW_MAX_CYC  = LOW_MAX_US * CLK_MHZ;
  localparam int HIGH_MAX_CYC = HIGH_MAX_US * CLK_MHZ;
  // Pauses the host must exceed; one spare cycle beyond the figure.
  localparam int LATCH_CYC    = LATCH_PAUSE_US * CLK_MHZ + 1;
  localparam int OFF_CYC      = OFF_TIME_US * CLK_MHZ + 1;
  localparam int CNT_W        = 16;
  localparam int LEVEL_W      = 6;
  localparam int LEVEL_MAX    = 32;
  // Current step in tenths of mA for level 1 (full scale).
  localparam int FULL_SCALE_TENTH_MA = 302;
endpackage

// >>> tb/plc_dev_model.sv
// Purpose: Behavioural model of the three-sink driver on its one wire.
// Assumes: Times in ns; the line is polled every 10 ns.
// Notes:   viol counts host timing breaches; no analog current shown.
`timescale 1ns/1ns
module plc_dev_model (
  // Control line.
  input  wire logic en_line,
  // Sink level codes, 0 is off.
  output logic [5:0] sink_output_one,
  output logic [5:0] sink_output_two,
  output logic [5:0] sink_output_three,
  // Status.
  output logic       shut,
  output int         viol
);
  logic [5:0] cnt = 6'h00;
  logic [5:0] lvl = 6'h00;
  time        t_chg = 0;
  time        t_rise = 0;
  time        w;
  initial shut = 1'b1;
  initial viol = 0;
  assign sink_output_one   = lvl;
  assign sink_output_two   = lvl;
  assign sink_output_three = lvl;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge en_line) begin
    w = $time - t_chg;
    if (w < 300 || (w > 75000 && w <= 500000)) viol++;
    if ($time - t_rise < 1000) viol++;
    t_rise = $time;
    t_chg = $time;
    if (shut) cnt = 6'h01;
    else if (cnt < 6'h20)
      cnt = cnt + 6'h01;
    shut = 1'b0;
  end
  // The first fall after power-up comes from an unknown level; skip it.
  always @(negedge en_line) begin
    w = $time - t_chg;
    // A high longer than a pulse but shorter than a latch is a breach.
    if (t_chg != 0 && (w < 50 || (w > 75000 && w < 500000)))
      viol++;
    t_chg = $time;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Polling keeps the model short at the cost of up to 10 ns of lag.
  always #10 begin
    if (en_line === 1'b1 && !shut && $time - t_chg >= 500000)
      lvl = cnt;
    if (en_line === 1'b0 && $time - t_chg > 500000) begin
      shut = 1'b1;
      cnt = 6'h00;
      lvl = 6'h00;
    end
  end
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the one-wire level host.
// Assumes: Inputs change on the falling edge of ref_clk.
// Notes:   A nonzero request costs about 50k cycles, a level 0 request about 25k, so rows are few.
`timescale 1ns/1ns
module tb_top;
  import plc_pkg::*;
  typedef struct {
    logic [LEVEL_W-1:0] lv;
    logic [LEVEL_W-1:0] exp;
  } plc_row_t;
  logic               ref_clk = 1'b0;
  logic               srst = 1'b1;
  logic               req_valid = 1'b0;
  logic [LEVEL_W-1:0] req_level = 6'h00;
  logic               req_ready, busy, en_line, shut;
  logic [LEVEL_W-1:0] level_applied, s1, s2, s3;
  int                 viol;
  int                 err_total = 0;
  int                 n_tests = 0;
  plc_row_t           rows [2] = '{'{6'h21, 6'h20}, '{6'h00, 6'h00}};
  plc_host DUT (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid),
    .req_level(req_level), .req_ready(req_ready), .busy(busy),
    .level_applied(level_applied), .en_line(en_line));
  plc_dev_model u_dev (.en_line(en_line), .sink_output_one(s1),
    .sink_output_two(s2), .sink_output_three(s3), .shut(shut), .viol(viol));
  initial forever #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic idle_chk;
    chk("en_line", 0, en_line);
    chk("req_ready", 1, req_ready);
    chk("busy", 0, busy);
    chk("level_applied", 0, level_applied);
  endtask
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A second request is raised while busy; it must leave no trace.
  task automatic run(input plc_row_t r);
    int k;
    req_valid = 1'b1;
    req_level = r.lv;
    @(negedge ref_clk);
    req_level = 6'h07;
    chk("busy", 1, busy);
    repeat (3) @(negedge ref_clk);
    req_valid = 1'b0;
    k = 0;
    while (req_ready !== 1'b1 && k < 60000) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (2) @(negedge ref_clk);
    chk("req_ready", 1, req_ready);
    chk("level_applied", r.exp, level_applied);
    chk("sink_one", r.exp, s1);
    chk("sink_two", r.exp, s2);
    chk("sink_three", r.exp, s3);
    chk("shut", r.exp == 0, shut);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge ref_clk);
    idle_chk();
    srst = 1'b0;
    foreach (rows[i]) run(rows[i]);
    req_valid = 1'b1;
    req_level = 6'h05;
    @(negedge ref_clk);
    req_valid = 1'b0;
    repeat (100) @(negedge ref_clk);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    idle_chk();
    chk("timing_viol", 0, viol);
    test_done();
  end
  initial begin
    #(100000 * 20);
    err_total++;
    test_done();
  end
endmodule
